// ### rtl/rff_consts.svh
`ifndef RFF_CONSTS_SVH
`define RFF_CONSTS_SVH

// register byte offsets
`define RFF_OFF_CTRL     8'h00
`define RFF_OFF_SIZE     8'h04
`define RFF_OFF_ISR      8'h08
`define RFF_OFF_IEN      8'h0c
`define RFF_OFF_ACC_VAL  8'h10
`define RFF_OFF_ACC_MSK  8'h14
`define RFF_OFF_REJ_VAL  8'h18
`define RFF_OFF_REJ_MSK  8'h1c
`define RFF_OFF_CH_SEL   8'h20
`define RFF_OFF_LOCK     8'h24
`define RFF_OFF_BCS_SEL  8'h28
`define RFF_OFF_BCS_DAT  8'h2c
`define RFF_OFF_WIN_ID   8'h40
`define RFF_OFF_WIN_SS   8'h44
`define RFF_OFF_WIN_DAT  8'h48
`define RFF_WORD_SHIFT   2

// ring geometry
`define RFF_MAX_BUFS     59
`define RFF_IDX_W        6
`define RFF_IDX_ZERO     6'h00
`define RFF_IDX_ONE      6'h01
`define RFF_MAX_IDX      6'h3b
`define RFF_SIZE_RST     6'h00

// frame fields
`define RFF_ID_W         11
`define RFF_SS_W         16
`define RFF_DWORD_W      16
`define RFF_DATA_WORDS   4

// field positions
`define RFF_CTRL_CFG     0
`define RFF_ISR_NE       0
`define RFF_ISR_OVR      1
`define RFF_LOCK_BIT     0
`define RFF_BCS_W        16
`define RFF_BCS_BUFFER_INTERRUPT_FLAG     1
`define RFF_BCS_ZERO     16'h0000

// bus answers
`define RFF_RESP_OKAY    2'h0
`define RFF_RESP_SLVERR  2'h2

`endif

// ### rtl/rff_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_consts.svh"

interface rff_filt_if;
  logic [`RFF_ID_W-1:0] id;
  logic                 chan;
  logic [`RFF_ID_W-1:0] acc_val;
  logic [`RFF_ID_W-1:0] acc_msk;
  logic [`RFF_ID_W-1:0] rej_val;
  logic [`RFF_ID_W-1:0] rej_msk;
  logic [1:0]           chan_sel;
  logic                 accept;

  modport top  (output id, chan, acc_val, acc_msk, rej_val, rej_msk, chan_sel,
                input accept);
  modport filt (input id, chan, acc_val, acc_msk, rej_val, rej_msk, chan_sel,
                output accept);
endinterface

`default_nettype wire

// ### rtl/rff_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_consts.svh"

module rff_filter (
  rff_filt_if.filt f
);

  // mask bit set means don't care
  function automatic logic id_match(input logic [`RFF_ID_W-1:0] id,
                                    input logic [`RFF_ID_W-1:0] val,
                                    input logic [`RFF_ID_W-1:0] msk);
    id_match = (((id ^ val) & ~msk) == '0); // [R20]
  endfunction

  logic acc_hit;
  logic rej_hit;

  assign acc_hit  = id_match(f.id, f.acc_val, f.acc_msk); // [R13]
  assign rej_hit  = id_match(f.id, f.rej_val, f.rej_msk); // [R14]
  // rejection overrides acceptance; channel must be enabled
  assign f.accept = f.chan_sel[f.chan] & acc_hit & ~rej_hit; // [R15] [R16]

endmodule // rff_filter

`default_nettype wire

// ### rtl/rff_pkg.sv
`include "rff_consts.svh"

package rff_pkg;

  typedef struct packed {
    logic [`RFF_ID_W-1:0] id;
    logic [`RFF_SS_W-1:0] ss;
  } rff_hdr_t;

  typedef enum logic {
    rff_ch_a,
    rff_ch_b
  } rff_chan_t;

endpackage

// ### rtl/rff_top.sv
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rff_consts.svh"

// Function
// (R1) ring starts at buffer 0, up to 59
// (R2) unfiltered frames passing fifo filters stored
// (R3) not-empty and overrun flags raise interrupts
// (R4) null and invalid frames never stored
// (R5) simultaneous channels: A stored before B
// (R6) write index increments, wraps to 0
// (R7) read index advances on each unlock
// (R8) full ring drops frame, flags overrun
// (R9) not empty while indices differ
// (R10) indices have no host access path
// (R11) lock on buffer 0 presents oldest entry
// (R12) host unlocks after reading entry
// (R13) acceptance compare ignores masked bits
// (R14) rejection compare uses own mask
// (R15) channel select gates filter per channel
// (R16) frame matching both filters is rejected
// (R17) configuration state keeps fifo contents
// (R18) first configuration entry clears buffer controls
// (R19) host zeroes buffer control before enlarging
// (R20) match is masked xor equal zero
module rff_top
  import rff_pkg::*;
#(
  parameter int AW    = 8,
  parameter int WORDS = `RFF_DATA_WORDS,
  parameter int NBUF  = `RFF_MAX_BUFS
) (
  // clock and reset
  input  wire  logic                                core_clk,
  input  wire  logic                                rst,
  // axi4-lite slave
  input  wire  logic [AW-1:0]                       s_axi_awaddr,
  input  wire  logic                                s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire  logic [31:0]                         s_axi_wdata,
  input  wire  logic [3:0]                          s_axi_wstrb,
  input  wire  logic                                s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire  logic                                s_axi_bready,
  input  wire  logic [AW-1:0]                       s_axi_araddr,
  input  wire  logic                                s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire  logic                                s_axi_rready,
  // frame receiver, index 0 is channel a
  input  wire  logic [1:0]                          rx_end,
  input  wire  logic [1:0][`RFF_ID_W-1:0]           rx_id,
  input  wire  logic [1:0][`RFF_SS_W-1:0]           rx_ss,
  input  wire  logic [1:0][WORDS*`RFF_DWORD_W-1:0]  rx_data,
  input  wire  logic [1:0]                          rx_null,
  input  wire  logic [1:0]                          rx_invalid,
  input  wire  logic [1:0]                          rx_error,
  input  wire  logic [1:0]                          rx_ded_match,
  // interrupts
  output logic                                      irq_not_empty,
  output logic                                      irq_overrun
);

  localparam int DW = WORDS * `RFF_DWORD_W;

  // host registers
  logic                 cfg_q;
  logic [`RFF_IDX_W-1:0] size_q;
  logic                 ovr_q;
  logic [1:0]           ien_q;
  logic [`RFF_ID_W-1:0] acc_val_q;
  logic [`RFF_ID_W-1:0] acc_msk_q;
  logic [`RFF_ID_W-1:0] rej_val_q;
  logic [`RFF_ID_W-1:0] rej_msk_q;
  logic [1:0]           ch_sel_q;
  logic                 lock_q;
  logic [`RFF_IDX_W-1:0] bcs_sel_q;
  logic                 cfg_seen_q;
  logic [`RFF_BCS_W-1:0] bcs_q [NBUF];

  // ring state, internal only
  logic [`RFF_IDX_W-1:0] wr_idx_q;
  logic [`RFF_IDX_W-1:0] rd_idx_q;
  logic                 full_q;
  rff_hdr_t             mem_hdr [NBUF];
  logic [DW-1:0]        mem_dat [NBUF];

  // channel b holding slot
  logic                 pend_v_q;
  rff_hdr_t             pend_hdr_q;
  logic [DW-1:0]        pend_dat_q;

  // axi state
  logic                 aw_v_q;
  logic [AW-1:0]        aw_addr_q;
  logic                 w_v_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;

  function automatic logic reg_hit(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    reg_hit = (b <= `RFF_OFF_BCS_DAT && b[1:0] == 2'h0) ||
              b == `RFF_OFF_WIN_ID || b == `RFF_OFF_WIN_SS ||
              (b >= `RFF_OFF_WIN_DAT && b[1:0] == 2'h0 &&
               ((b - `RFF_OFF_WIN_DAT) >> `RFF_WORD_SHIFT) < 8'(WORDS));
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    strb_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        strb_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic [`RFF_IDX_W-1:0] ring_next(
      input logic [`RFF_IDX_W-1:0] i, input logic [`RFF_IDX_W-1:0] sz);
    ring_next = (i >= sz - `RFF_IDX_ONE) ? `RFF_IDX_ZERO : i + `RFF_IDX_ONE; // [R6]
  endfunction

  // write decode
  logic       wr_en;
  logic [7:0] wa;
  logic [31:0] wd;
  logic       wr_hit;
  assign wr_en  = aw_v_q & w_v_q & ~bvalid_q;
  assign wa     = 8'(aw_addr_q);
  assign wr_hit = reg_hit(aw_addr_q);

  function automatic logic [31:0] cur_val(input logic [7:0] a);
    case (a)
      `RFF_OFF_CTRL:    cur_val = 32'(cfg_q);
      `RFF_OFF_SIZE:    cur_val = 32'(size_q);
      `RFF_OFF_IEN:     cur_val = 32'(ien_q);
      `RFF_OFF_ACC_VAL: cur_val = 32'(acc_val_q);
      `RFF_OFF_ACC_MSK: cur_val = 32'(acc_msk_q);
      `RFF_OFF_REJ_VAL: cur_val = 32'(rej_val_q);
      `RFF_OFF_REJ_MSK: cur_val = 32'(rej_msk_q);
      `RFF_OFF_CH_SEL:  cur_val = 32'(ch_sel_q);
      `RFF_OFF_BCS_SEL: cur_val = 32'(bcs_sel_q);
      default:          cur_val = 32'h0000_0000;
    endcase
  endfunction

  always_comb wd = strb_merge(cur_val(wa), w_data_q, w_strb_q);

  // filters per channel
  rff_filt_if fi [2] ();
  logic [1:0] cand;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign fi[g].id       = rx_id[g];
      assign fi[g].chan     = 1'(g);
      assign fi[g].acc_val  = acc_val_q;
      assign fi[g].acc_msk  = acc_msk_q;
      assign fi[g].rej_val  = rej_val_q;
      assign fi[g].rej_msk  = rej_msk_q;
      assign fi[g].chan_sel = ch_sel_q;
      rff_filter u_filt (
        .f (fi[g])
      );
      // error frames neither stored nor counted as overrun
      assign cand[g] = rx_end[g] & ~rx_null[g] & ~rx_invalid[g] & ~rx_error[g] &
                       ~rx_ded_match[g] & fi[g].accept & ~cfg_q; // [R2] [R4]
    end
  endgenerate

  // store selection, pending b first, then a, then b
  logic       store_v;
  rff_hdr_t   store_hdr;
  logic [DW-1:0] store_dat;
  logic       do_store;
  logic       ovr_set;
  logic       pop;
  logic       not_empty;
  logic [`RFF_IDX_W-1:0] wr_next;
  logic [`RFF_IDX_W-1:0] rd_next;

  always_comb begin
    store_v   = pend_v_q | cand[rff_ch_a] | cand[rff_ch_b];
    store_hdr = pend_hdr_q;
    store_dat = pend_dat_q;
    if (!pend_v_q && cand[rff_ch_a]) begin // [R5]
      store_hdr = '{id: rx_id[rff_ch_a], ss: rx_ss[rff_ch_a]};
      store_dat = rx_data[rff_ch_a];
    end else if (!pend_v_q) begin
      store_hdr = '{id: rx_id[rff_ch_b], ss: rx_ss[rff_ch_b]};
      store_dat = rx_data[rff_ch_b];
    end
  end

  assign do_store  = store_v & ~full_q & (size_q != `RFF_SIZE_RST); // [R8]
  assign ovr_set   = store_v & full_q; // [R8]
  assign not_empty = (wr_idx_q != rd_idx_q) | full_q; // [R9]
  assign pop       = wr_en & (wa == `RFF_OFF_LOCK) & w_strb_q[0] &
                     w_data_q[`RFF_LOCK_BIT] & lock_q; // [R7]
  assign wr_next   = ring_next(wr_idx_q, size_q);
  assign rd_next   = ring_next(rd_idx_q, size_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_v_q   <= 1'b0;
      pend_hdr_q <= '0;
      pend_dat_q <= '0;
    end else begin
      // a collision with a held frame is not expected; frames last many cycles
      pend_v_q <= ~pend_v_q & cand[rff_ch_a] & cand[rff_ch_b]; // [R5]
      if (~pend_v_q & cand[rff_ch_a] & cand[rff_ch_b]) begin
        pend_hdr_q <= '{id: rx_id[rff_ch_b], ss: rx_ss[rff_ch_b]};
        pend_dat_q <= rx_data[rff_ch_b];
      end
    end
  end

  // ring indices; untouched by configuration state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_idx_q <= `RFF_IDX_ZERO; // [R1]
      rd_idx_q <= `RFF_IDX_ZERO;
      full_q   <= 1'b0;
    end else begin
      if (do_store) begin
        wr_idx_q <= wr_next; // [R6]
      end
      if (pop) begin
        rd_idx_q <= rd_next; // [R7]
      end
      if (do_store && !pop) begin
        full_q <= (wr_next == rd_idx_q); // [R8]
      end else if (pop && !do_store) begin
        full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_store) begin
      mem_hdr[wr_idx_q] <= store_hdr; // [R2] [R17]
      mem_dat[wr_idx_q] <= store_dat;
    end
  end

  // control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q     <= 1'b0;
      size_q    <= `RFF_SIZE_RST;
      ien_q     <= '0;
      acc_val_q <= '0;
      acc_msk_q <= '0;
      rej_val_q <= '0;
      rej_msk_q <= '0;
      ch_sel_q  <= '0;
      bcs_sel_q <= `RFF_IDX_ZERO;
    end else if (wr_en) begin
      case (wa)
        `RFF_OFF_CTRL:    cfg_q     <= wd[`RFF_CTRL_CFG];
        `RFF_OFF_SIZE:    size_q    <= (wd[`RFF_IDX_W-1:0] > `RFF_MAX_IDX) ?
                                       `RFF_MAX_IDX : wd[`RFF_IDX_W-1:0]; // [R1]
        `RFF_OFF_IEN:     ien_q     <= wd[1:0];
        `RFF_OFF_ACC_VAL: acc_val_q <= wd[`RFF_ID_W-1:0];
        `RFF_OFF_ACC_MSK: acc_msk_q <= wd[`RFF_ID_W-1:0];
        `RFF_OFF_REJ_VAL: rej_val_q <= wd[`RFF_ID_W-1:0];
        `RFF_OFF_REJ_MSK: rej_msk_q <= wd[`RFF_ID_W-1:0];
        `RFF_OFF_CH_SEL:  ch_sel_q  <= wd[1:0];
        `RFF_OFF_BCS_SEL: bcs_sel_q <= wd[`RFF_IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // overrun flag, set wins over write-one-to-clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (ovr_set) begin
      ovr_q <= 1'b1; // [R3] [R8]
    end else if (wr_en && wa == `RFF_OFF_ISR && w_strb_q[0] &&
                 w_data_q[`RFF_ISR_OVR]) begin
      ovr_q <= 1'b0;
    end
  end

  // lock handshake on buffer 0
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (wr_en && wa == `RFF_OFF_LOCK && w_strb_q[0] &&
                 w_data_q[`RFF_LOCK_BIT]) begin
      lock_q <= lock_q ? 1'b0 : not_empty; // [R11] [R12]
    end
  end

  // buffer control status of fifo buffers
  logic cfg_first;
  assign cfg_first = cfg_q & ~cfg_seen_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_seen_q <= 1'b0;
      for (int i = 0; i < NBUF; i++) begin
        bcs_q[i] <= `RFF_BCS_ZERO;
      end
    end else begin
      if (cfg_q) begin
        cfg_seen_q <= 1'b1;
      end
      for (int i = 0; i < NBUF; i++) begin
        if (cfg_first) begin
          bcs_q[i] <= `RFF_BCS_ZERO; // [R18]
        end else begin
          if (wr_en && wa == `RFF_OFF_BCS_DAT && bcs_sel_q == `RFF_IDX_W'(i)) begin
            bcs_q[i] <= `RFF_BCS_W'(strb_merge(32'(bcs_q[i]), w_data_q,
                                               w_strb_q)); // [R19]
          end
          if (pop && rd_idx_q == `RFF_IDX_W'(i)) begin
            bcs_q[i][`RFF_BCS_BUFFER_INTERRUPT_FLAG] <= 1'b0;
          end
          if (do_store && wr_idx_q == `RFF_IDX_W'(i)) begin
            bcs_q[i][`RFF_BCS_BUFFER_INTERRUPT_FLAG] <= 1'b1;
          end
        end
      end
    end
  end

  // axi write channel
  assign s_axi_awready = ~aw_v_q & ~bvalid_q;
  assign s_axi_wready  = ~w_v_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_v_q    <= 1'b0;
      aw_addr_q <= '0;
      w_v_q     <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RFF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_v_q    <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_v_q    <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_v_q   <= 1'b0;
        w_v_q    <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `RFF_RESP_OKAY : `RFF_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel; indices never appear here
  logic [7:0]  ra;
  logic [31:0] rd_word;
  logic [7:0]  dword_k;
  assign ra      = 8'(s_axi_araddr);
  assign dword_k = (ra - `RFF_OFF_WIN_DAT) >> `RFF_WORD_SHIFT;

  always_comb begin
    rd_word = cur_val(ra); // [R10]
    case (ra)
      `RFF_OFF_ISR:     rd_word = {30'h0, ovr_q, not_empty}; // [R3] [R9]
      `RFF_OFF_LOCK:    rd_word = 32'(lock_q); // [R11]
      `RFF_OFF_BCS_DAT: rd_word = (bcs_sel_q < `RFF_IDX_W'(NBUF)) ?
                                  32'(bcs_q[bcs_sel_q]) : 32'h0000_0000;
      `RFF_OFF_WIN_ID:  rd_word = lock_q ? 32'(mem_hdr[rd_idx_q].id) : 32'h0; // [R11]
      `RFF_OFF_WIN_SS:  rd_word = lock_q ? 32'(mem_hdr[rd_idx_q].ss) : 32'h0;
      default: begin
        if (lock_q && ra >= `RFF_OFF_WIN_DAT && dword_k < 8'(WORDS)) begin
          rd_word = 32'(mem_dat[rd_idx_q][dword_k*`RFF_DWORD_W +: `RFF_DWORD_W]);
        end
      end
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `RFF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= reg_hit(s_axi_araddr) ? rd_word : 32'h0000_0000;
      rresp_q  <= reg_hit(s_axi_araddr) ? `RFF_RESP_OKAY : `RFF_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // interrupt outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_not_empty <= 1'b0;
      irq_overrun   <= 1'b0;
    end else begin
      irq_not_empty <= not_empty & ien_q[`RFF_ISR_NE]; // [R3]
      irq_overrun   <= ovr_q & ien_q[`RFF_ISR_OVR]; // [R3]
    end
  end

endmodule // rff_top

`default_nettype wire

// ### testbench/rff_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_consts.svh"

module rff_rx_model #(
  parameter int WORDS = `RFF_DATA_WORDS
) (
  // clock
  input  wire logic                                 core_clk,
  // frame receiver lines
  output logic [1:0]                                rx_end,
  output logic [1:0][`RFF_ID_W-1:0]                 rx_id,
  output logic [1:0][`RFF_SS_W-1:0]                 rx_ss,
  output logic [1:0][WORDS*`RFF_DWORD_W-1:0]        rx_data,
  output logic [1:0]                                rx_null,
  output logic [1:0]                                rx_invalid,
  output logic [1:0]                                rx_error,
  output logic [1:0]                                rx_ded_match
);
  initial begin
    rx_end = 2'h0;
    rx_id = '0;
    rx_ss = '0;
    rx_data = '0;
    {rx_null, rx_invalid, rx_error, rx_ded_match} = 8'h00;
  end

  // fl: bit0 null, bit1 invalid, bit2 error, bit3 dedicated match
  task automatic frame(input logic [1:0] m, input logic [10:0] ida, input logic [10:0] idb,
                       input logic [3:0] fl);
    @(posedge core_clk);
    rx_end <= m;
    rx_id <= {idb, ida};
    rx_ss <= {5'h0a, idb, 5'h0a, ida};
    rx_data <= {(WORDS*16)'(idb), (WORDS*16)'(ida)};
    {rx_ded_match, rx_error, rx_invalid, rx_null} <= {{2{fl[3]}}, {2{fl[2]}}, {2{fl[1]}},
                                                      {2{fl[0]}}};
    @(posedge core_clk);
    // outside a frame the lines carry junk, not the last value
    rx_end <= 2'h0;
    rx_id <= ~rx_id;
    rx_ss <= ~rx_ss;
    rx_data <= ~rx_data;
    {rx_null, rx_invalid, rx_error, rx_ded_match} <= 8'h5a;
  endtask
endmodule // rff_rx_model

`default_nettype wire

// ### testbench/rff_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module rff_top_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // receiver and interrupts
  input wire logic [1:0]  rx_end,
  input wire logic        irq_not_empty,
  input wire logic        irq_overrun
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // not-empty rises only after a frame end or a register write
  chk_ne_cause: assert property ($rose(irq_not_empty) |->
    $past(rx_end, 2) != 2'h0 || $past(rx_end[1], 3) || $past(s_axi_bvalid))
    else $error("not-empty rose without cause");
  chk_ovr_cause: assert property ($rose(irq_overrun) |->
    $past(rx_end, 2) != 2'h0 || $past(rx_end[1], 3) || $past(s_axi_bvalid))
    else $error("overrun rose without cause");
  // draining needs an unlock write
  chk_ne_drop: assert property ($fell(irq_not_empty) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("not-empty fell without a write");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after taken");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response held after taken");
endmodule // rff_top_sva

bind rff_top rff_top_sva u_rff_top_sva (.core_clk, .rst, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .rx_end, .irq_not_empty, .irq_overrun);

`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_consts.svh"

module tb_top;
  typedef struct packed {
    logic [10:0] id;
    logic [1:0]  m;
    logic [3:0]  fl;
    logic        st;
  } rff_row_t;

  logic              core_clk, rst;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [1:0]        rx_end, rx_null, rx_invalid, rx_error, rx_ded_match;
  logic [1:0][10:0]  rx_id;
  logic [1:0][15:0]  rx_ss;
  logic [1:0][63:0]  rx_data;
  logic              irq_not_empty, irq_overrun;
  logic [1:0]        lastb, lastr;
  int                n_mismatch, compares;
  rff_row_t          rows [8];

  rff_top u_rff_top (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_end, .rx_id, .rx_ss,
    .rx_data, .rx_null, .rx_invalid, .rx_error, .rx_ded_match, .irq_not_empty,
    .irq_overrun);

  rff_rx_model u_rff_rx_model (.core_clk, .rx_end, .rx_id, .rx_ss, .rx_data, .rx_null,
    .rx_invalid, .rx_error, .rx_ded_match);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("mismatch %0t word %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge core_clk);
      if (aw_p && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    lastb = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    lastr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic expect_isr(input logic [31:0] exp);
    logic [31:0] d;
    rd(`RFF_OFF_ISR, d);
    chk_word(d, exp);
  endtask

  task automatic pop(input logic [10:0] id);
    logic [31:0] d;
    wr(`RFF_OFF_LOCK, 32'h1);
    rd(`RFF_OFF_LOCK, d);
    chk_word(d, 32'h1);
    rd(`RFF_OFF_WIN_ID, d);
    chk_word(d, {21'h0, id});
    rd(`RFF_OFF_WIN_SS, d);
    chk_word(d, {16'h0, 5'h0a, id});
    wr(`RFF_OFF_LOCK, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    int i;
    logic [31:0] d;
    rows[0] = '{11'h123, 2'h1, 4'h0, 1'b1};
    rows[1] = '{11'h12f, 2'h2, 4'h0, 1'b1};
    rows[2] = '{11'h133, 2'h1, 4'h0, 1'b0};
    rows[3] = '{11'h125, 2'h1, 4'h0, 1'b0};
    rows[4] = '{11'h123, 2'h1, 4'h1, 1'b0};
    rows[5] = '{11'h123, 2'h2, 4'h2, 1'b0};
    rows[6] = '{11'h123, 2'h1, 4'h4, 1'b0};
    rows[7] = '{11'h123, 2'h2, 4'h8, 1'b0};
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    expect_isr(32'h0);
    chk_bit(irq_not_empty, 1'b0);
    wr(`RFF_OFF_SIZE, 32'h3f);
    rd(`RFF_OFF_SIZE, d);
    chk_word(d, 32'h3b);
    for (i = 0; i < 4; i++) begin
      wr(`RFF_OFF_BCS_SEL, i);
      wr(`RFF_OFF_BCS_DAT, 32'h0);
    end
    wr(`RFF_OFF_SIZE, 32'h4);
    wr(`RFF_OFF_ACC_VAL, 32'h120);
    wr(`RFF_OFF_ACC_MSK, 32'h00f);
    wr(`RFF_OFF_REJ_VAL, 32'h125);
    wr(`RFF_OFF_REJ_MSK, 32'h0);
    wr(`RFF_OFF_CH_SEL, 32'h3);
    wr(`RFF_OFF_IEN, 32'h3);
    // acceptance, rejection and qualifier cases, one frame each
    for (i = 0; i < 8; i++) begin
      u_rff_rx_model.frame(rows[i].m, rows[i].id, rows[i].id, rows[i].fl);
      expect_isr({31'h0, rows[i].st});
      chk_bit(irq_not_empty, rows[i].st);
      if (rows[i].st)
        pop(rows[i].id);
      expect_isr(32'h0);
    end
    // locking an empty ring is refused
    wr(`RFF_OFF_LOCK, 32'h1);
    rd(`RFF_OFF_LOCK, d);
    chk_word(d, 32'h0);
    // fill the ring, then errored and good frames when full
    for (i = 0; i < 4; i++)
      u_rff_rx_model.frame(2'h1, 11'h120 + i, 11'h0, 4'h0);
    u_rff_rx_model.frame(2'h1, 11'h12e, 11'h0, 4'h4);
    expect_isr(32'h1);
    u_rff_rx_model.frame(2'h1, 11'h12e, 11'h0, 4'h0);
    expect_isr(32'h3);
    chk_bit(irq_overrun, 1'b1);
    wr(`RFF_OFF_ISR, 32'h2);
    for (i = 0; i < 4; i++)
      pop(11'h120 + i);
    expect_isr(32'h0);
    // channel select removes channel b
    wr(`RFF_OFF_CH_SEL, 32'h1);
    u_rff_rx_model.frame(2'h2, 11'h0, 11'h123, 4'h0);
    expect_isr(32'h0);
    wr(`RFF_OFF_CH_SEL, 32'h3);
    // both channels end together
    u_rff_rx_model.frame(2'h3, 11'h121, 11'h122, 4'h0);
    pop(11'h121);
    pop(11'h122);
    // configuration state keeps the entry, clears buffer control
    u_rff_rx_model.frame(2'h1, 11'h124, 11'h0, 4'h0);
    wr(`RFF_OFF_BCS_SEL, 32'h0);
    rd(`RFF_OFF_BCS_DAT, d);
    chk_bit(d[`RFF_BCS_BUFFER_INTERRUPT_FLAG], 1'b1);
    wr(`RFF_OFF_CTRL, 32'h1);
    rd(`RFF_OFF_BCS_DAT, d);
    chk_word(d, 32'h0);
    wr(`RFF_OFF_CTRL, 32'h0);
    expect_isr(32'h1);
    pop(11'h124);
    // indices have no address of their own
    rd(8'h30, d);
    chk_word({lastr, d}, {`RFF_RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h1);
    chk_word({30'h0, lastb}, {30'h0, `RFF_RESP_SLVERR});
    close_out();
  end
endmodule // tb_top

`default_nettype wire
